// *** hdl/fspc_pkg.sv ***
// Constants, register map and state type of the flash self-program control.
// Assumes a 40 MHz pclk and an APB master that addresses whole words.
package fspc_pkg;
    // Register byte offsets.
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] UNLK_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS = 8'h0c;
    localparam logic [7:0] PH_OFS = 8'h10;
    localparam logic [7:0] PL_OFS = 8'h14;
    localparam logic [7:0] CH_OFS = 8'h18;
    localparam logic [7:0] CL_OFS = 8'h1c;
    localparam logic [7:0] WD_OFS = 8'h20;
    localparam logic [7:0] RD_OFS = 8'h24;
    localparam logic [7:0] PROT_OFS = 8'h28;
    // Status and control bit positions.
    localparam int PERR_BIT = 0;
    localparam int CFAIL_BIT = 1;
    localparam int BUSY_BIT = 2;
    localparam int MODE_BIT = 0;
    localparam int PROT_BIT = 0;
    // Key that opens the one-shot unlock window.
    localparam logic [7:0] UNLOCK_KEY = 8'ha5;
    // Command codes.
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_VERIFY = 8'h01;
    localparam logic [7:0] CMD_BLANK = 8'h02;
    localparam logic [7:0] CMD_ERASE = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h04;
    // Byte values of erased flash and of the last byte of a block.
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] LAST_BYTE = 8'hff;
    // Halt release timing.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int HALT_MAX_PS = 10000000;
    localparam int HALT_EXTRA_CLK = 2;
    localparam int HALT_REL_CYC = HALT_MAX_PS / CLK_PERIOD_PS + HALT_EXTRA_CLK;
    localparam int HCW = 9;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_SCAN,
        ST_WRITE
    } fspc_state_t;
endpackage : fspc_pkg

// *** hdl/fspc_top.sv ***
// Flash self-program control: APB register file, unlock sequence, mode
// control, halt release timer and erase from offset cl to the block end, write and check engine.
// Assumes the CPU raises cpu_halt while it sits in its halt instruction.
`timescale 1ns/100ps
module fspc_top #(
    parameter int BLK_BITS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_halt,
    input wire logic security_on,
    output logic pin_halt_hold,
    output logic irq_suppress,
    output logic halt_release
);
    localparam int AW = BLK_BITS + 8;
    localparam int HLAST = fspc_pkg::HALT_REL_CYC - 1;
    // Last count of the halt timer, at the width of the counter itself.
    localparam logic [fspc_pkg::HCW-1:0] HCNT_LAST = HLAST[fspc_pkg::HCW-1:0];

    typedef struct packed {
        fspc_pkg::fspc_state_t st;
        logic mode;
        logic unlk;
        logic perr;
        logic cfail;
        logic arm;
        logic hrel;
        logic [fspc_pkg::HCW-1:0] hcnt;
        logic [7:0] cmd;
        logic [7:0] ph;
        logic [7:0] pl;
        logic [7:0] ch;
        logic [7:0] cl;
        logic [7:0] wd;
        logic [7:0] prot;
        logic [7:0] idx;
        logic rdy;
        logic err;
        logic [31:0] rdat;
    } fspc_regs_t;

    fspc_regs_t s_r;
    fspc_regs_t s_nxt;
    logic [7:0] mem [0:(1<<AW)-1];
    logic mem_we;
    logic [AW-1:0] mem_a;
    logic [7:0] mem_d;
    logic [7:0] mem_q;
    logic [7:0] mem_rd;
    logic wr_go;

    // Flash byte address from a block number and a byte offset.
    function automatic logic [AW-1:0] fspc_faddr(input logic [7:0] blk,
                                                 input logic [7:0] ofs);
        return {blk[BLK_BITS-1:0], ofs};
    endfunction : fspc_faddr

    // True when the byte offset names a register of this block.
    function automatic logic fspc_mapped(input logic [7:0] a);
        case (a)
            fspc_pkg::MODE_OFS, fspc_pkg::UNLK_OFS, fspc_pkg::STAT_OFS,
            fspc_pkg::CMD_OFS, fspc_pkg::PH_OFS, fspc_pkg::PL_OFS,
            fspc_pkg::CH_OFS, fspc_pkg::CL_OFS, fspc_pkg::WD_OFS,
            fspc_pkg::RD_OFS, fspc_pkg::PROT_OFS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : fspc_mapped

    // A byte write works at the pointer, the engines at their running index;
    // kept out of the next-state process so it never reads its own output.
    assign mem_a = (s_r.st == fspc_pkg::ST_WRITE) ?
                   fspc_faddr(s_r.ph, s_r.pl) : fspc_faddr(s_r.ph, s_r.idx);
    assign mem_q = mem[mem_a];
    assign mem_rd = mem[fspc_faddr(s_r.ph, s_r.pl)];
    // Writes land at the edge where pready is seen high, never before.
    assign wr_go = psel && penable && pwrite && s_r.rdy;

    // Next state of the whole block.
    always_comb begin
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_d = fspc_pkg::BLANK_BYTE;
        s_nxt.rdy = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.hrel = 1'b0;
        // First access cycle: prepare the answer, pready follows next edge.
        if (psel && penable && !s_r.rdy) begin
            s_nxt.rdy = 1'b1;
            s_nxt.err = !fspc_mapped(paddr);
            s_nxt.rdat = 32'h0000_0000;
            case (paddr)
                fspc_pkg::MODE_OFS: s_nxt.rdat[fspc_pkg::MODE_BIT] = s_r.mode;
                fspc_pkg::STAT_OFS: begin
                    s_nxt.rdat[fspc_pkg::PERR_BIT] = s_r.perr;
                    s_nxt.rdat[fspc_pkg::CFAIL_BIT] = s_r.cfail;
                    s_nxt.rdat[fspc_pkg::BUSY_BIT] =
                        s_r.st != fspc_pkg::ST_IDLE;
                end
                fspc_pkg::CMD_OFS: s_nxt.rdat[7:0] = s_r.cmd;
                fspc_pkg::PH_OFS: s_nxt.rdat[7:0] = s_r.ph;
                fspc_pkg::PL_OFS: s_nxt.rdat[7:0] = s_r.pl;
                fspc_pkg::CH_OFS: s_nxt.rdat[7:0] = s_r.ch;
                fspc_pkg::CL_OFS: s_nxt.rdat[7:0] = s_r.cl;
                fspc_pkg::WD_OFS: s_nxt.rdat[7:0] = s_r.wd;
                // Security hides flash data only outside the mode.
                fspc_pkg::RD_OFS: begin
                    if (s_r.mode || !security_on) begin
                        s_nxt.rdat[7:0] = mem_rd;
                    end
                end
                fspc_pkg::PROT_OFS: s_nxt.rdat[7:0] = s_r.prot;
                default: s_nxt.rdat = 32'h0000_0000;
            endcase
        end
        // Halt release timer: runs only while the CPU halts after entry.
        if (s_r.arm && s_r.mode && cpu_halt) begin
            if (s_r.hcnt == HCNT_LAST) begin
                s_nxt.hrel = 1'b1;
                s_nxt.arm = 1'b0;
                s_nxt.hcnt = '0;
            end else begin
                s_nxt.hcnt = s_r.hcnt + 1'b1;
            end
        end
        // Register writes.
        if (wr_go) begin
            if (s_r.unlk) begin
                s_nxt.unlk = 1'b0;
            end
            case (paddr)
                fspc_pkg::UNLK_OFS: begin
                    s_nxt.unlk = pwdata[7:0] == fspc_pkg::UNLOCK_KEY;
                end
                fspc_pkg::MODE_OFS: begin
                    // A locked or mid-operation mode write is refused.
                    if (s_r.unlk && s_r.st == fspc_pkg::ST_IDLE) begin
                        s_nxt.mode = pwdata[fspc_pkg::MODE_BIT];
                        s_nxt.arm = pwdata[fspc_pkg::MODE_BIT];
                        s_nxt.hcnt = '0;
                    end else begin
                        s_nxt.perr = 1'b1;
                    end
                end
                // Writing zero clears a flag; writing one leaves it as it is.
                fspc_pkg::STAT_OFS: begin
                    if (!pwdata[fspc_pkg::PERR_BIT]) begin
                        s_nxt.perr = 1'b0;
                    end
                    if (!pwdata[fspc_pkg::CFAIL_BIT]) begin
                        s_nxt.cfail = 1'b0;
                    end
                end
                fspc_pkg::CMD_OFS: begin
                    s_nxt.cmd = pwdata[7:0];
                    // Commands start only in the mode and when idle.
                    if (s_r.mode && s_r.st == fspc_pkg::ST_IDLE) begin
                        s_nxt.cfail = 1'b0;
                        case (pwdata[7:0])
                            fspc_pkg::CMD_ERASE, fspc_pkg::CMD_WRITE: begin
                                // Protection bit alone vetoes changes.
                                if (s_r.prot[fspc_pkg::PROT_BIT]) begin
                                    s_nxt.cfail = 1'b1;
                                end else if (pwdata[7:0] ==
                                             fspc_pkg::CMD_ERASE) begin
                                    s_nxt.st = fspc_pkg::ST_ERASE;
                                    s_nxt.idx = s_r.cl;
                                end else begin
                                    s_nxt.st = fspc_pkg::ST_WRITE;
                                end
                            end
                            fspc_pkg::CMD_BLANK, fspc_pkg::CMD_VERIFY: begin
                                s_nxt.st = fspc_pkg::ST_SCAN;
                                s_nxt.idx = s_r.pl;
                            end
                            default: s_nxt.st = fspc_pkg::ST_IDLE;
                        endcase
                    end
                end
                fspc_pkg::PH_OFS: s_nxt.ph = pwdata[7:0];
                fspc_pkg::PL_OFS: s_nxt.pl = pwdata[7:0];
                fspc_pkg::CH_OFS: s_nxt.ch = pwdata[7:0];
                fspc_pkg::CL_OFS: s_nxt.cl = pwdata[7:0];
                fspc_pkg::WD_OFS: s_nxt.wd = pwdata[7:0];
                fspc_pkg::PROT_OFS: s_nxt.prot = pwdata[7:0];
                default: s_nxt.unlk = 1'b0;
            endcase
            // Any write other than mode while unlocked, the key included, raises perr.
            if (s_r.unlk && paddr != fspc_pkg::MODE_OFS) begin
                s_nxt.perr = 1'b1;
            end
        end
        // Engine; placed last so its failure flag beats a clear.
        case (s_r.st)
            fspc_pkg::ST_IDLE: s_nxt.st = s_nxt.st;
            fspc_pkg::ST_ERASE: begin
                mem_we = 1'b1;
                mem_d = fspc_pkg::BLANK_BYTE;
                s_nxt.idx = s_r.idx + 1'b1;
                if (s_r.idx == fspc_pkg::LAST_BYTE) begin
                    s_nxt.st = fspc_pkg::ST_IDLE;
                end
            end
            fspc_pkg::ST_SCAN: begin
                if (s_r.cmd == fspc_pkg::CMD_BLANK &&
                    mem_q != fspc_pkg::BLANK_BYTE) begin
                    s_nxt.cfail = 1'b1;
                end
                s_nxt.idx = s_r.idx + 1'b1;
                if (s_r.idx == s_r.cl || s_r.ph != s_r.ch) begin
                    s_nxt.st = fspc_pkg::ST_IDLE;
                end
            end
            fspc_pkg::ST_WRITE: begin
                // Flash only clears bits; a bit that must rise fails.
                mem_we = 1'b1;
                mem_d = mem_q & s_r.wd;
                if ((mem_q & s_r.wd) != s_r.wd) begin
                    s_nxt.cfail = 1'b1;
                end
                s_nxt.st = fspc_pkg::ST_IDLE;
            end
            default: s_nxt.st = fspc_pkg::ST_IDLE;
        endcase
    end

    // State register; a reset mid-operation simply abandons it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Flash array has no reset, so a cut-off erase leaves mixed data.
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_a] <= mem_d;
        end
    end

    assign prdata = s_r.rdat;
    assign pready = s_r.rdy;
    assign pslverr = s_r.err;
    assign pin_halt_hold = s_r.mode;
    assign irq_suppress = s_r.mode;
    assign halt_release = s_r.hrel;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pins;
        (wr_go && paddr == fspc_pkg::MODE_OFS && s_r.unlk &&
         s_r.st == fspc_pkg::ST_IDLE && pwdata[fspc_pkg::MODE_BIT])
        |=> pin_halt_hold;
    endproperty
    a_pins: assert property (p_pins) else $error("pins not held");
    // Both directions of an accepted mode write must reach the mask.
    property p_irq;
        (wr_go && paddr == fspc_pkg::MODE_OFS && s_r.unlk &&
         s_r.st == fspc_pkg::ST_IDLE)
        |=> irq_suppress == $past(pwdata[fspc_pkg::MODE_BIT]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not masked");
    property p_sec;
        (wr_go && paddr == fspc_pkg::CMD_OFS && s_r.mode &&
         s_r.st == fspc_pkg::ST_IDLE && pwdata[7:0] == fspc_pkg::CMD_BLANK)
        |=> s_r.st == fspc_pkg::ST_SCAN;
    endproperty
    a_sec: assert property (p_sec) else $error("command blocked");
    property p_prot;
        (wr_go && paddr == fspc_pkg::CMD_OFS && s_r.mode &&
         s_r.st == fspc_pkg::ST_IDLE && s_r.prot[fspc_pkg::PROT_BIT] &&
         pwdata[7:0] == fspc_pkg::CMD_ERASE)
        |=> s_r.st == fspc_pkg::ST_IDLE && s_r.cfail;
    endproperty
    a_prot: assert property (p_prot) else $error("protect ignored");
    property p_hrel;
        (s_r.arm && s_r.mode && cpu_halt && s_r.hcnt == HCNT_LAST)
        |=> halt_release && !s_r.arm ##1 !halt_release;
    endproperty
    a_hrel: assert property (p_hrel) else $error("halt not released");
    property p_hcause;
        halt_release |-> $past(s_r.hcnt) == HCNT_LAST;
    endproperty
    a_hcause: assert property (p_hcause) else $error("early release");
    property p_erase;
        s_r.st == fspc_pkg::ST_ERASE |-> mem_we &&
                                         mem_d == fspc_pkg::BLANK_BYTE;
    endproperty
    a_erase: assert property (p_erase) else $error("erase not ones");
    property p_lock;
        (wr_go && paddr == fspc_pkg::MODE_OFS && !s_r.unlk)
        |=> $stable(s_r.mode) && s_r.perr;
    endproperty
    a_lock: assert property (p_lock) else $error("locked mode write");

    c_entry: cover property (wr_go && paddr == fspc_pkg::MODE_OFS &&
                             s_r.unlk && pwdata[fspc_pkg::MODE_BIT]);
    c_hrel: cover property (halt_release);
    c_erase: cover property (s_r.st == fspc_pkg::ST_ERASE ##1
                             s_r.st == fspc_pkg::ST_ERASE);
    c_wfail: cover property (s_r.st == fspc_pkg::ST_WRITE ##1 s_r.cfail);
endmodule : fspc_top

// *** tb/fspc_cpu_model.sv ***
// Behavioural model of the CPU that runs the self-programming firmware.
// Assumes the bench asks for the halt with a one-cycle halt_req pulse.
`timescale 1ns/100ps
module fspc_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic halt_req,
    input wire logic halt_release,
    output logic cpu_halt
);
    // The firmware halts right after entering the mode and waits for the
    // device to wake it; it never leaves the halt by itself.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_halt <= 1'b0;
        end else if (halt_release) begin
            cpu_halt <= 1'b0;
        end else if (halt_req) begin
            cpu_halt <= 1'b1;
        end
    end
endmodule : fspc_cpu_model

// *** tb/tb.sv ***
// Self-checking bench for the flash self-program control.
// Assumes the register map and timing of the design package and notes.
`timescale 1ns/100ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, security_on, halt_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, cpu_halt, pin_halt_hold, irq_suppress;
    logic halt_release, e;
    logic [7:0] blk, b, d, d2, fb;
    int err_count, n_tests, cnt;
    // Eight microseconds of settling after the halt, at the 25 ns clock.
    localparam int SETTLE_CYC = 8000 / 25;

    fspc_top fspc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halt(cpu_halt), .security_on(security_on),
        .pin_halt_hold(pin_halt_hold), .irq_suppress(irq_suppress),
        .halt_release(halt_release));
    fspc_cpu_model fspc_cpu_model_inst (.pclk(pclk), .presetn(presetn),
        .halt_req(halt_req), .halt_release(halt_release),
        .cpu_halt(cpu_halt));

    // A 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
            err_count++;
        end
    endtask : chk

    // One APB transfer; nothing is released before pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            err_count++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] dat);
        apb(1'b1, a, {24'h0, dat});
    endtask : wr

    // Polls the status word until the engine is idle, under a bound.
    task wait_idle;
        int i;
        for (i = 0; i < 200; i++) begin
            apb(1'b0, fspc_pkg::STAT_OFS, 32'h0);
            if (r[fspc_pkg::BUSY_BIT] === 1'b0) break;
        end
        if (i == 200) begin
            err_count++;
            stop_test();
        end
    endtask : wait_idle

    function automatic logic [7:0] prog(input logic [7:0] o,
                                        input logic [7:0] n);
        return o & n;
    endfunction : prog

    // The mode change always runs the same unlock sequence.
    task set_mode(input logic [7:0] m);
        wr(fspc_pkg::CMD_OFS, 8'h00);
        wr(fspc_pkg::UNLK_OFS, fspc_pkg::UNLOCK_KEY);
        wr(fspc_pkg::MODE_OFS, m);
        // Lets the new mode reach the outputs before anyone looks.
        @(posedge pclk);
    endtask : set_mode

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        security_on = 1'b0;
        halt_req = 1'b0;
        err_count = 0;
        n_tests = 0;
        void'($urandom(83806));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk({pin_halt_hold, irq_suppress, halt_release}, 32'h0);
        apb(1'b0, fspc_pkg::STAT_OFS, 32'h0);
        chk(r, 32'h0);
        // Unmapped address is refused.
        apb(1'b1, 8'h3c, 32'h5a);
        chk({31'h0, e}, 32'h1);
        // Mode write without the key, then key followed by another write.
        wr(fspc_pkg::MODE_OFS, 8'h01);
        @(posedge pclk);
        chk({31'h0, pin_halt_hold}, 32'h0);
        apb(1'b0, fspc_pkg::STAT_OFS, 32'h0);
        chk(r[fspc_pkg::PERR_BIT], 1'b1);
        wr(fspc_pkg::STAT_OFS, 8'h00);
        wr(fspc_pkg::UNLK_OFS, fspc_pkg::UNLOCK_KEY);
        wr(fspc_pkg::PH_OFS, 8'h00);
        apb(1'b0, fspc_pkg::STAT_OFS, 32'h0);
        chk(r[fspc_pkg::PERR_BIT], 1'b1);
        wr(fspc_pkg::STAT_OFS, 8'h00);
        set_mode(8'h01);
        chk({31'h0, pin_halt_hold}, 32'h1);
        chk({31'h0, irq_suppress}, 32'h1);
        // Halt after entry must be released automatically in time.
        @(posedge pclk);
        halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        cnt = 0;
        while (halt_release !== 1'b1 && cnt < 1000) begin
            @(posedge pclk);
            cnt++;
        end
        chk({31'h0, cnt <= fspc_pkg::HALT_REL_CYC + 1}, 32'h1);
        if (cnt == 1000) begin
            err_count++;
            stop_test();
        end
        // The firmware lets the clock settle before its first command.
        repeat (SETTLE_CYC) @(posedge pclk);
        // Block erase with security on; it must not matter in the mode.
        security_on <= 1'b1;
        blk = 8'($urandom_range(0, 15));
        b = 8'($urandom);
        d = 8'($urandom);
        d2 = 8'($urandom);
        wr(fspc_pkg::PH_OFS, blk);
        wr(fspc_pkg::CH_OFS, blk);
        wr(fspc_pkg::CL_OFS, 8'h00);
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_ERASE);
        wait_idle();
        wr(fspc_pkg::PL_OFS, b);
        apb(1'b0, fspc_pkg::RD_OFS, 32'h0);
        chk(r, {24'h0, fspc_pkg::BLANK_BYTE});
        // Two byte writes; the second may need bits to rise.
        fb = prog(fspc_pkg::BLANK_BYTE, d);
        wr(fspc_pkg::WD_OFS, d);
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_WRITE);
        wait_idle();
        chk(r[fspc_pkg::CFAIL_BIT], 1'b0);
        apb(1'b0, fspc_pkg::RD_OFS, 32'h0);
        chk(r, {24'h0, fb});
        wr(fspc_pkg::WD_OFS, d2);
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_WRITE);
        wait_idle();
        chk(r[fspc_pkg::CFAIL_BIT], ((~fb & d2) != 8'h00));
        fb = prog(fb, d2);
        wr(fspc_pkg::STAT_OFS, 8'h00);
        // Blank check over the whole block sees the written byte.
        wr(fspc_pkg::PL_OFS, 8'h00);
        wr(fspc_pkg::CL_OFS, 8'hff);
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_BLANK);
        wait_idle();
        chk(r[fspc_pkg::CFAIL_BIT], (fb != 8'hff));
        wr(fspc_pkg::STAT_OFS, 8'h00);
        // Verify over the same block runs to its end and never fails.
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_VERIFY);
        wait_idle();
        chk(r[fspc_pkg::CFAIL_BIT], 1'b0);
        // Protected erase is refused and leaves the byte alone.
        wr(fspc_pkg::PROT_OFS, 8'h01);
        wr(fspc_pkg::CL_OFS, 8'h00);
        wr(fspc_pkg::CMD_OFS, fspc_pkg::CMD_ERASE);
        wait_idle();
        chk(r[fspc_pkg::CFAIL_BIT], 1'b1);
        wr(fspc_pkg::PL_OFS, b);
        apb(1'b0, fspc_pkg::RD_OFS, 32'h0);
        chk(r, {24'h0, fb});
        // Back to normal mode: security hides the flash again.
        wr(fspc_pkg::PROT_OFS, 8'h00);
        set_mode(8'h00);
        chk({31'h0, pin_halt_hold}, 32'h0);
        chk({31'h0, irq_suppress}, 32'h0);
        apb(1'b0, fspc_pkg::RD_OFS, 32'h0);
        chk(r, 32'h0);
        stop_test();
    end
endmodule : tb
